/* src/udsf_top.sv */
// device port registers: axi4-lite slave, frame capture, device state, interrupts
`timescale 1ns/100ps
module udsf_top (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// events from the packet engine, same clock
	input wire udsf_pkg::udsf_sof_evt_t sof_evt,
	input wire logic bus_reset_end,
	input wire logic suspend_det,
	input wire logic resume_det,
	input wire logic ext_resume_det,
	input wire logic wakeup_det,
	input wire logic [5:0] ep_irq,
	// remote wake request pin, asynchronous
	input wire logic remote_wake_req,
	// endpoint register window
	output udsf_pkg::udsf_ep_req_t ep_req,
	input wire logic [31:0] ep_rdata,
	// device state
	output logic address_state_enable,
	output logic configured_state,
	output logic [6:0] function_address_value,
	output logic function_endpoint_enable,
	output logic [31:0] endpoint_reset,
	output logic [31:0] transceiver_control,
	output logic irq
);
	import udsf_pkg::*;

	typedef enum logic [1:0] {
		RD_IDLE,
		RD_LOCAL,
		RD_EP,
		RD_RESP
	} udsf_rd_state_t;

	// write channel state
	logic awready_q;
	logic aw_got_q;
	logic [7:0] awaddr_q;
	logic wready_q;
	logic w_got_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;

	// read channel state
	udsf_rd_state_t rd_state_q;
	logic arready_q;
	logic [7:0] araddr_q;
	logic [31:0] rdata_q;
	logic rvalid_q;

	// device state registers
	logic addr_state_q;
	logic config_q;
	logic [6:0] function_address_value_q;
	logic fen_q;
	logic [31:0] ep_reset_q;
	logic [31:0] xcvr_q;
	logic wake_meta_q;
	logic wake_sync_q;
	udsf_ep_req_t ep_req_q;

	// submodule outputs
	logic [10:0] frame_index;
	logic frame_error_flag;
	logic frame_good_flag;
	logic [13:0] irq_status;
	logic [13:0] irq_mask;
	logic irq_line;

	// handshakes
	logic aw_hs;
	logic w_hs;
	logic b_hs;
	logic ar_hs;
	logic r_hs;
	logic wr_go;
	assign aw_hs = s_axi_awvalid & awready_q;
	assign w_hs = s_axi_wvalid & wready_q;
	assign b_hs = bvalid_q & s_axi_bready;
	assign ar_hs = s_axi_arvalid & arready_q;
	assign r_hs = rvalid_q & s_axi_rready;
	assign wr_go = aw_got_q & w_got_q & ~bvalid_q;

	// write decode on the word address
	logic [7:0] wa;
	logic [31:0] wd_eff;
	logic wr_gs;
	logic wr_fa;
	logic wr_ien;
	logic wr_idis;
	logic wr_iclr;
	logic wr_eprst;
	logic wr_xcvr;
	logic wr_csr;
	logic wr_fifo;
	logic wr_ep;
	assign wa = {awaddr_q[7:2], 2'h0};
	assign wd_eff = wdata_q & strb_mask(wstrb_q);
	assign wr_gs = wr_go & (wa == OFF_GLOBAL_STATE);
	assign wr_fa = wr_go & (wa == OFF_FUNC_ADDRESS);
	assign wr_ien = wr_go & (wa == OFF_IRQ_ENABLE);
	assign wr_idis = wr_go & (wa == OFF_IRQ_DISABLE);
	assign wr_iclr = wr_go & (wa == OFF_IRQ_CLEAR);
	assign wr_eprst = wr_go & (wa == OFF_EP_RESET);
	assign wr_xcvr = wr_go & (wa == OFF_XCVR_CTRL);
	assign wr_csr = in_ep_window(wa, OFF_EP_CSR_BASE);
	assign wr_fifo = in_ep_window(wa, OFF_EP_FIFO_BASE);
	assign wr_ep = wr_go & (wr_csr | wr_fifo);

	// read decode on the latched word address
	logic [7:0] ra;
	logic rd_csr;
	logic rd_fifo;
	logic rd_ep;
	logic [31:0] frame_word;
	logic [31:0] gstate_word;
	logic [31:0] faddr_word;
	logic [31:0] rd_val;
	assign ra = {araddr_q[7:2], 2'h0};
	assign rd_csr = in_ep_window(ra, OFF_EP_CSR_BASE);
	assign rd_fifo = in_ep_window(ra, OFF_EP_FIFO_BASE);
	assign rd_ep = rd_csr | rd_fifo;

	// read words, unassigned bits are zero
	assign frame_word = 32'(frame_index)
		| (32'(frame_error_flag) << FRAME_ERR_BIT)
		| (32'(frame_good_flag) << FRAME_GOOD_BIT);
	assign gstate_word = (32'(addr_state_q) << ADDR_STATE_BIT)
		| (32'(config_q) << CONFIG_BIT)
		| (32'(wake_sync_q) << RESUME_BIT);
	assign faddr_word = 32'(function_address_value_q) | (32'(fen_q) << FEN_BIT);

	// write-only and reserved offsets read as zero
	assign rd_val = (ra == OFF_FRAME_NUMBER) ? frame_word :
		(ra == OFF_GLOBAL_STATE) ? gstate_word :
		(ra == OFF_FUNC_ADDRESS) ? faddr_word :
		(ra == OFF_IRQ_MASK) ? 32'(irq_mask) :
		(ra == OFF_IRQ_STATUS) ? 32'(irq_status) :
		(ra == OFF_EP_RESET) ? ep_reset_q :
		(ra == OFF_XCVR_CTRL) ? xcvr_q :
		32'h0000_0000;

	// interrupt sources, frame bit taken at the identifier
	logic [13:0] evt;
	assign evt = {wakeup_det, bus_reset_end, sof_evt.pid, ext_resume_det,
		resume_det, suspend_det, 2'h0, ep_irq};

	// write-address channel, held until the response is taken
	always_ff @(posedge clock) begin
		if (rst) begin
			awready_q <= 1'b1;
			aw_got_q <= 1'b0;
			awaddr_q <= 8'h00;
		end else if (ce) begin
			if (aw_hs) begin
				awaddr_q <= s_axi_awaddr;
				aw_got_q <= 1'b1;
				awready_q <= 1'b0;
			end else if (b_hs) begin
				aw_got_q <= 1'b0;
				awready_q <= 1'b1;
			end
		end
	end

	// write-data channel, either order against the address
	always_ff @(posedge clock) begin
		if (rst) begin
			wready_q <= 1'b1;
			w_got_q <= 1'b0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else if (ce) begin
			if (w_hs) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				w_got_q <= 1'b1;
				wready_q <= 1'b0;
			end else if (b_hs) begin
				w_got_q <= 1'b0;
				wready_q <= 1'b1;
			end
		end
	end

	// response one cycle after both halves are in
	always_ff @(posedge clock) begin
		if (rst) begin
			bvalid_q <= 1'b0;
		end else if (ce) begin
			if (wr_go) begin
				bvalid_q <= 1'b1;
			end else if (b_hs) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// read sequencer; endpoint read waits out an endpoint write
	always_ff @(posedge clock) begin
		if (rst) begin
			rd_state_q <= RD_IDLE;
			arready_q <= 1'b1;
			araddr_q <= 8'h00;
			rdata_q <= 32'h0000_0000;
			rvalid_q <= 1'b0;
		end else if (ce) begin
			case (rd_state_q)
				RD_IDLE: begin
					if (ar_hs) begin
						araddr_q <= s_axi_araddr;
						arready_q <= 1'b0;
						rd_state_q <= RD_LOCAL;
					end
				end
				RD_LOCAL: begin
					if (rd_ep) begin
						if (!wr_ep) begin
							rd_state_q <= RD_EP;
						end
					end else begin
						rdata_q <= rd_val;
						rvalid_q <= 1'b1;
						rd_state_q <= RD_RESP;
					end
				end
				RD_EP: begin
					rdata_q <= ep_rdata;
					rvalid_q <= 1'b1;
					rd_state_q <= RD_RESP;
				end
				RD_RESP: begin
					if (r_hs) begin
						rvalid_q <= 1'b0;
						arready_q <= 1'b1;
						rd_state_q <= RD_IDLE;
					end
				end
				default: begin
					rd_state_q <= RD_IDLE;
				end
			endcase
		end
	end

	// endpoint access pulse, one cycle per transfer
	always_ff @(posedge clock) begin
		if (rst) begin
			ep_req_q <= '0;
		end else if (ce) begin
			ep_req_q.valid <= wr_ep | (rd_state_q == RD_LOCAL && rd_ep && !wr_ep);
			if (wr_ep) begin
				ep_req_q.write <= 1'b1;
				ep_req_q.fifo <= wr_fifo;
				ep_req_q.num <= ep_number(wa, wr_fifo ? OFF_EP_FIFO_BASE : OFF_EP_CSR_BASE);
				ep_req_q.strb <= wstrb_q;
				ep_req_q.wdata <= wdata_q;
			end else if (rd_state_q == RD_LOCAL && rd_ep) begin
				ep_req_q.write <= 1'b0;
				ep_req_q.fifo <= rd_fifo;
				ep_req_q.num <= ep_number(ra, rd_fifo ? OFF_EP_FIFO_BASE : OFF_EP_CSR_BASE);
				ep_req_q.strb <= 4'h0;
				ep_req_q.wdata <= 32'h0000_0000;
			end
		end
	end

	// device state; a bus reset takes the device back to default
	always_ff @(posedge clock) begin
		if (rst) begin
			addr_state_q <= 1'b0;
			config_q <= 1'b0;
		end else if (ce) begin
			if (bus_reset_end) begin
				addr_state_q <= 1'b0;
				config_q <= 1'b0;
			end else if (wr_gs) begin
				if (wd_eff[ADDR_STATE_BIT]) begin
					addr_state_q <= 1'b1;
				end
				if (wstrb_q[0]) begin
					config_q <= wdata_q[CONFIG_BIT];
				end
			end
		end
	end

	// function address and enable
	always_ff @(posedge clock) begin
		if (rst) begin
			function_address_value_q <= FUNC_ADDRESS_RESET[6:0];
			fen_q <= FUNC_ADDRESS_RESET[FEN_BIT];
		end else if (ce) begin
			if (bus_reset_end) begin
				function_address_value_q <= FUNC_ADDRESS_RESET[6:0];
			end else if (wr_fa) begin
				if (wstrb_q[0]) begin
					function_address_value_q <= wdata_q[FUNCTION_ADDRESS_VALUE_W-1:0];
				end
				if (wstrb_q[1]) begin
					fen_q <= wdata_q[FEN_BIT];
				end
			end
		end
	end

	// plain storage words
	always_ff @(posedge clock) begin
		if (rst) begin
			ep_reset_q <= EP_RESET_RESET;
			xcvr_q <= XCVR_CTRL_RESET;
		end else if (ce) begin
			if (wr_eprst) begin
				ep_reset_q <= apply_strb(ep_reset_q, wdata_q, wstrb_q);
			end
			if (wr_xcvr) begin
				xcvr_q <= apply_strb(xcvr_q, wdata_q, wstrb_q);
			end
		end
	end

	// pin synchroniser; only the second stage is read
	always_ff @(posedge clock) begin
		if (rst) begin
			wake_meta_q <= 1'b0;
			wake_sync_q <= 1'b0;
		end else if (ce) begin
			wake_meta_q <= remote_wake_req;
			wake_sync_q <= wake_meta_q;
		end
	end

	udsf_sof_capture u_sof (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.sof_evt(sof_evt),
		.frame_index(frame_index),
		.frame_error_flag(frame_error_flag),
		.frame_good_flag(frame_good_flag)
	);

	udsf_irq_ctrl u_irq (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.evt(evt),
		.bus_reset_end(bus_reset_end),
		.set_en(wr_ien ? wd_eff[13:0] : 14'h0000),
		.set_dis(wr_idis ? wd_eff[13:0] : 14'h0000),
		.clr(wr_iclr ? wd_eff[13:0] : 14'h0000),
		.status(irq_status),
		.mask(irq_mask),
		.irq(irq_line)
	);

	// outputs straight from registers, both responses tied to OKAY
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bresp = RESP_OKAY;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = RESP_OKAY;
	assign s_axi_rvalid = rvalid_q;
	assign ep_req = ep_req_q;
	assign address_state_enable = addr_state_q;
	assign configured_state = config_q;
	assign function_address_value = function_address_value_q;
	assign function_endpoint_enable = fen_q;
	assign endpoint_reset = ep_reset_q;
	assign transceiver_control = xcvr_q;
	assign irq = irq_line;
endmodule

/* pkg/udsf_pkg.sv */
// constants, field layouts and carrier types of the device port register block
package udsf_pkg;

	// register word offsets (byte addresses)
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_FRAME_NUMBER = 8'h00;
	localparam logic [7:0] OFF_GLOBAL_STATE = 8'h04;
	localparam logic [7:0] OFF_FUNC_ADDRESS = 8'h08;
	localparam logic [7:0] OFF_IRQ_ENABLE = 8'h10;
	localparam logic [7:0] OFF_IRQ_DISABLE = 8'h14;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h1C;
	localparam logic [7:0] OFF_IRQ_CLEAR = 8'h20;
	localparam logic [7:0] OFF_EP_RESET = 8'h28;
	localparam logic [7:0] OFF_EP_CSR_BASE = 8'h30;
	localparam logic [7:0] OFF_EP_FIFO_BASE = 8'h50;
	localparam logic [7:0] OFF_XCVR_CTRL = 8'h74;
	localparam logic [7:0] EP_WINDOW = 8'h20;

	// field positions
	localparam int FRAME_IDX_W = 11;
	localparam int FRAME_ERR_BIT = 16;
	localparam int FRAME_GOOD_BIT = 17;
	localparam int ADDR_STATE_BIT = 0;
	localparam int CONFIG_BIT = 1;
	localparam int RESUME_BIT = 3;
	localparam int FUNCTION_ADDRESS_VALUE_W = 7;
	localparam int FEN_BIT = 8;

	// interrupt bit positions
	localparam int IRQ_W = 14;
	localparam int IRQ_EP_N = 6;
	localparam int IRQ_RXSUSP = 8;
	localparam int IRQ_RXRSM = 9;
	localparam int IRQ_EXTRSM = 10;
	localparam int IRQ_SOF = 11;
	localparam int IRQ_BUSRES = 12;
	localparam int IRQ_WAKEUP = 13;
	localparam logic [13:0] IRQ_USED = 14'h3F3F;
	localparam logic [13:0] IMR_RESET = 14'h1200;
	localparam logic [13:0] IMR_FIXED = 14'h1000;

	// reset values
	localparam logic [31:0] FUNC_ADDRESS_RESET = 32'h0000_0100;
	localparam logic [31:0] EP_RESET_RESET = 32'h0000_0000;
	localparam logic [31:0] XCVR_CTRL_RESET = 32'h0000_0100;
	localparam logic [1:0] RESP_OKAY = 2'h0;

	// start-of-frame events from the packet engine
	typedef struct packed {
		logic pid;
		logic eop;
		logic err;
		logic [10:0] count;
	} udsf_sof_evt_t;

	// forwarded endpoint register access
	typedef struct packed {
		logic valid;
		logic write;
		logic fifo;
		logic [3:0] num;
		logic [3:0] strb;
		logic [31:0] wdata;
	} udsf_ep_req_t;

	// byte enables widened to a bit mask
	function automatic logic [31:0] strb_mask(input logic [3:0] strb);
		strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction

	// merge a write into a stored word lane by lane
	function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		apply_strb = (old & ~strb_mask(strb)) | (nw & strb_mask(strb));
	endfunction

	// address inside an endpoint window
	function automatic logic in_ep_window(input logic [7:0] a, input logic [7:0] base);
		in_ep_window = (a >= base) && (a < 8'(base + EP_WINDOW));
	endfunction

	// endpoint number of a window address, first slot is endpoint 1
	function automatic logic [3:0] ep_number(input logic [7:0] a, input logic [7:0] base);
		logic [7:0] off;
		off = 8'(a - base);
		ep_number = {1'b0, off[4:2]} + 4'h1;
	endfunction

endpackage

/* src/udsf_sof_capture.sv */
// start-of-frame index capture with error and good flags
`timescale 1ns/100ps
module udsf_sof_capture (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	// frame events
	input wire udsf_pkg::udsf_sof_evt_t sof_evt,
	// captured state
	output logic [10:0] frame_index,
	output logic frame_error_flag,
	output logic frame_good_flag
);
	import udsf_pkg::*;

	logic [10:0] idx_q;
	logic err_q;
	logic good_q;

	// flags drop on the identifier, the end of packet sets them; set wins
	always_ff @(posedge clock) begin
		if (rst) begin
			idx_q <= 11'h000;
			err_q <= 1'b0;
			good_q <= 1'b0;
		end else if (ce) begin
			if (sof_evt.eop) begin
				idx_q <= sof_evt.count;
			end
			if (sof_evt.eop && sof_evt.err) begin
				err_q <= 1'b1;
			end else if (sof_evt.pid) begin
				err_q <= 1'b0;
			end
			if (sof_evt.eop && !sof_evt.err) begin
				good_q <= 1'b1;
			end else if (sof_evt.pid) begin
				good_q <= 1'b0;
			end
		end
	end

	assign frame_index = idx_q;
	assign frame_error_flag = err_q;
	assign frame_good_flag = good_q;
endmodule

/* src/udsf_irq_ctrl.sv */
// sticky interrupt status, mask and one irq line
`timescale 1ns/100ps
module udsf_irq_ctrl (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	// events and bus reset end
	input wire logic [13:0] evt,
	input wire logic bus_reset_end,
	// software writes, one-hot per bit
	input wire logic [13:0] set_en,
	input wire logic [13:0] set_dis,
	input wire logic [13:0] clr,
	// state
	output logic [13:0] status,
	output logic [13:0] mask,
	output logic irq
);
	import udsf_pkg::*;

	logic [13:0] status_q;
	logic [13:0] mask_q;
	logic irq_q;
	logic [13:0] status_d;
	logic [13:0] mask_d;

	// an event in the clearing cycle survives the clear
	assign status_d = ((status_q & ~clr) | evt) & IRQ_USED;
	// bus reset end puts the mask back to its reset layout
	assign mask_d = bus_reset_end ? IMR_RESET : ((mask_q | set_en) & ~set_dis & IRQ_USED);

	// status resets to zero though software must not count on it
	always_ff @(posedge clock) begin
		if (rst) begin
			status_q <= 14'h0000;
			mask_q <= IMR_RESET;
			irq_q <= 1'b0;
		end else if (ce) begin
			status_q <= status_d;
			mask_q <= mask_d;
			irq_q <= |(status_d & (mask_d | IMR_FIXED));
		end
	end

	assign status = status_q;
	assign mask = mask_q | IMR_FIXED;
	assign irq = irq_q;
endmodule

/* tb/udsf_top_asserts.sv */
// concurrent checks on the device port block ports
`timescale 1ns/100ps
module udsf_top_asserts (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// axi4-lite handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// endpoint window, events and state
	input wire udsf_pkg::udsf_ep_req_t ep_req,
	input wire logic bus_reset_end,
	input wire logic address_state_enable,
	input wire logic configured_state,
	input wire logic [6:0] function_address_value,
	input wire logic function_endpoint_enable,
	input wire logic irq
);
	import udsf_pkg::*;
	logic ep_hit;
	logic ep_fifo;
	logic [7:0] ep_off;
	logic [3:0] ep_num;
	// endpoint window decode of the read address
	assign ep_hit = (s_axi_araddr >= 8'h30) && (s_axi_araddr < 8'h70);
	assign ep_fifo = s_axi_araddr >= 8'h50;
	assign ep_off = s_axi_araddr - (ep_fifo ? 8'h50 : 8'h30);
	assign ep_num = {1'b0, ep_off[4:2]} + 4'h1;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	property p_wr_resp;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("late write response");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
	property p_ready_back;
		s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready;
	endproperty
	a_ready_back: assert property (p_ready_back) else $error("write not ready again");
	property p_rd_lat;
		s_axi_arvalid && s_axi_arready && !ep_hit |=> !s_axi_rvalid ##1 s_axi_rvalid;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("late local read");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data moved");
	property p_ep_fwd;
		s_axi_arvalid && s_axi_arready && ep_hit |-> ##2 ep_req.valid && !ep_req.write
			&& ep_req.fifo == $past(ep_fifo, 2) && ep_req.num == $past(ep_num, 2);
	endproperty
	a_ep_fwd: assert property (p_ep_fwd) else $error("endpoint read misrouted");
	property p_addr_sticky;
		address_state_enable && !bus_reset_end |=> address_state_enable;
	endproperty
	a_addr_sticky: assert property (p_addr_sticky) else $error("address state lost");
	property p_reset_vals;
		$fell(rst) |-> function_address_value == 7'h00 && function_endpoint_enable
			&& !address_state_enable && !configured_state;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("bad reset state");
	property p_busres;
		bus_reset_end |=> (!address_state_enable && !configured_state
			&& function_address_value == 7'h00) ##[0:1] irq;
	endproperty
	a_busres: assert property (p_busres) else $error("bus reset end missed");
endmodule

bind udsf_top udsf_top_asserts i_udsf_top_asserts (.clock(clock), .rst(rst),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.ep_req(ep_req), .bus_reset_end(bus_reset_end), .address_state_enable(address_state_enable),
	.configured_state(configured_state), .function_address_value(function_address_value),
	.function_endpoint_enable(function_endpoint_enable), .irq(irq));

/* tb/udsf_partner.sv */
// packet engine and endpoint register model
`timescale 1ns/100ps
module udsf_partner (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// endpoint window
	input wire udsf_pkg::udsf_ep_req_t ep_req,
	output logic [31:0] ep_rdata,
	// frame events
	output udsf_pkg::udsf_sof_evt_t sof_evt
);
	import udsf_pkg::*;
	logic [31:0] mem_q [16];
	logic [31:0] cnt_q;
	logic [3:0] idx;
	// slot: window select, endpoint number minus one
	assign idx = {ep_req.fifo, 3'(ep_req.num - 4'h1)};
	// wander when not read
	assign ep_rdata = (ep_req.valid && !ep_req.write) ? mem_q[idx] : ~cnt_q;
	// endpoint registers, written by forwarded requests
	always_ff @(posedge clock) begin
		cnt_q <= rst ? 32'h0 : cnt_q + 32'h1;
		if (ep_req.valid && ep_req.write) begin
			mem_q[idx] <= ep_req.wdata;
		end
	end
	initial sof_evt = '0;
	// token: identifier, gap, end of packet with count
	task automatic send_sof(input logic [10:0] c, input logic e, input int gap);
		@(posedge clock);
		sof_evt <= '{pid: 1'b1, eop: 1'b0, err: 1'b0, count: ~c};
		@(posedge clock);
		sof_evt.pid <= 1'b0;
		repeat (gap) @(posedge clock);
		sof_evt <= '{pid: 1'b0, eop: 1'b1, err: e, count: c};
		@(posedge clock);
		sof_evt <= '{pid: 1'b0, eop: 1'b0, err: ~e, count: ~c};
	endtask
endmodule

/* tb/udsf_top_bench.sv */
// register-level bench of the device port block over axi4-lite
`timescale 1ns/100ps
module udsf_top_bench;
	import udsf_pkg::*;
	logic clock, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, ep_rdata, endpoint_reset, transceiver_control, v;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [13:0] evt_q;
	logic remote_wake_req, address_state_enable, configured_state, function_endpoint_enable;
	logic [6:0] function_address_value;
	udsf_ep_req_t ep_req;
	udsf_sof_evt_t sof_evt;
	int n_fail, check_count, slow;
	logic [7:0] ra [12] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20, 8'h24,
		8'h28, 8'h74, 8'hFC};
	logic [31:0] rv [12] = '{32'h0, 32'h0, 32'h100, 32'h0, 32'h0, 32'h0, 32'h1200, 32'h0,
		32'h0, 32'h0, 32'h100, 32'h0};
	logic [31:0] gd [4] = '{32'h1, 32'h0, 32'h3, 32'h1};
	logic [31:0] ge [4] = '{32'h1, 32'h1, 32'h3, 32'h1};
	// ce and prot tied
	udsf_top i_udsf_top (.clock(clock), .rst(rst), .ce(1'b1), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.sof_evt(sof_evt), .bus_reset_end(evt_q[12]), .suspend_det(evt_q[8]),
		.resume_det(evt_q[9]), .ext_resume_det(evt_q[10]), .wakeup_det(evt_q[13]),
		.ep_irq(evt_q[5:0]), .remote_wake_req(remote_wake_req), .ep_req(ep_req),
		.ep_rdata(ep_rdata), .address_state_enable(address_state_enable),
		.configured_state(configured_state), .function_address_value(function_address_value),
		.function_endpoint_enable(function_endpoint_enable), .endpoint_reset(endpoint_reset),
		.transceiver_control(transceiver_control), .irq(irq));
	udsf_partner i_udsf_partner (.clock(clock), .rst(rst), .ep_req(ep_req), .ep_rdata(ep_rdata),
		.sof_evt(sof_evt));
	// compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
			n_fail++;
		end
	endtask
	task automatic settle;
		repeat (2) @(posedge clock);
		#1;
	endtask
	// one write, each channel dropped when taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic aw_ok = 1'b0, w_ok = 1'b0;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= (slow == 0);
		while (!(aw_ok && w_ok)) begin
			@(posedge clock);
			if (!aw_ok && s_axi_awready === 1'b1) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready === 1'b1) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		// slow master delays bready
		repeat (slow * 3) @(posedge clock);
		s_axi_bready <= 1'b1;
		do @(posedge clock); while (s_axi_bvalid !== 1'b1);
		check({30'h0, s_axi_bresp}, 32'h0);
		s_axi_bready <= 1'b0;
	endtask
	// one read, data taken at the handshake edge
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= (slow == 0);
		do @(posedge clock); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		repeat (slow * 4) @(posedge clock);
		s_axi_rready <= 1'b1;
		do @(posedge clock); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		check({30'h0, s_axi_rresp}, 32'h0);
		s_axi_rready <= 1'b0;
	endtask
	task automatic pulse(input logic [13:0] m);
		@(posedge clock);
		evt_q <= m;
		@(posedge clock);
		evt_q <= 14'h0;
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// hang guard, well past the few hundred cycles needed
	initial begin
		repeat (20000) @(posedge clock);
		n_fail++;
		test_done;
	end
	initial begin
		{rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{evt_q, remote_wake_req} = '0;
		{n_fail, check_count, slow} = '0;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		// reset values, then the same after writes to read-only and reserved words
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 12; i++) begin
				axi_rd(ra[i], v);
				check(v, rv[i]);
				if (p == 0 && i inside {0, 3, 6, 8, 11}) axi_wr(ra[i], 32'hFFFF_FFFF, 4'hF);
			end
		end
		// frame capture, flags cleared at the next identifier
		axi_wr(OFF_IRQ_ENABLE, 32'h800, 4'hF);
		i_udsf_partner.send_sof(11'h7FF, 1'b0, 2);
		settle;
		axi_rd(OFF_FRAME_NUMBER, v);
		check(v, 32'h0002_07FF);
		fork
			i_udsf_partner.send_sof(11'h123, 1'b1, 60);
			begin
				repeat (4) @(posedge clock);
				axi_rd(OFF_FRAME_NUMBER, v);
				check(v, 32'h0000_07FF);
				axi_rd(OFF_IRQ_STATUS, v);
				check(v & 32'h800, 32'h800);
				check({31'h0, irq}, 32'h1);
			end
		join
		settle;
		axi_rd(OFF_FRAME_NUMBER, v);
		check(v, 32'h0001_0123);
		axi_wr(OFF_IRQ_CLEAR, 32'h800, 4'hF);
		axi_wr(OFF_IRQ_DISABLE, 32'h800, 4'hF);
		// address first, then state bits written both ways
		axi_wr(OFF_FUNC_ADDRESS, 32'h105, 4'hF);
		axi_rd(OFF_FUNC_ADDRESS, v);
		check(v, 32'h105);
		slow = 1;
		for (int i = 0; i < 4; i++) begin
			axi_wr(OFF_GLOBAL_STATE, gd[i], 4'hF);
			axi_rd(OFF_GLOBAL_STATE, v);
			check(v, ge[i]);
		end
		slow = 0;
		axi_wr(OFF_FUNC_ADDRESS, 32'h7F, 4'hF);
		settle;
		check({25'h0, function_address_value}, 32'h7F);
		check({31'h0, function_endpoint_enable}, 32'h0);
		@(posedge clock);
		remote_wake_req <= 1'b1;
		settle;
		axi_rd(OFF_GLOBAL_STATE, v);
		check(v, 32'h9);
		remote_wake_req <= 1'b0;
		settle;
		axi_rd(OFF_GLOBAL_STATE, v);
		check(v, 32'h1);
		// every event source at once except the frame identifier
		pulse(14'h373F);
		settle;
		axi_rd(OFF_IRQ_STATUS, v);
		check(v, 32'h373F);
		check({31'h0, address_state_enable}, 32'h0);
		axi_rd(OFF_IRQ_MASK, v);
		check(v, 32'h1200);
		check({31'h0, irq}, 32'h1);
		axi_wr(OFF_IRQ_CLEAR, 32'h1200, 4'hF);
		settle;
		check({31'h0, irq}, 32'h0);
		axi_wr(OFF_IRQ_ENABLE, 32'h100, 4'hF);
		settle;
		check({31'h0, irq}, 32'h1);
		axi_wr(OFF_IRQ_DISABLE, 32'h100, 4'hF);
		axi_wr(OFF_IRQ_CLEAR, 32'h3FFF, 4'hF);
		settle;
		check({31'h0, irq}, 32'h0);
		axi_rd(OFF_IRQ_STATUS, v);
		check(v, 32'h0);
		// both endpoint windows, every slot
		for (int i = 0; i < 8; i++) begin
			axi_wr(8'(OFF_EP_CSR_BASE + 8'(4 * i)), 32'hA000 + i, 4'hF);
			axi_wr(8'(OFF_EP_FIFO_BASE + 8'(4 * i)), 32'hB000 + i, 4'hF);
		end
		for (int i = 0; i < 8; i++) begin
			axi_rd(8'(OFF_EP_CSR_BASE + 8'(4 * i)), v);
			check(v, 32'hA000 + i);
			axi_rd(8'(OFF_EP_FIFO_BASE + 8'(4 * i)), v);
			check(v, 32'hB000 + i);
		end
		// byte lanes on plain storage words
		axi_wr(OFF_EP_RESET, 32'h1234_5678, 4'h5);
		axi_wr(OFF_XCVR_CTRL, 32'hFFFF_FFFF, 4'h2);
		axi_rd(OFF_EP_RESET, v);
		check(v, 32'h0034_0078);
		check(endpoint_reset, 32'h0034_0078);
		check(transceiver_control, 32'h0000_FF00);
		test_done;
	end
endmodule
